// ---- core/scrb_defs.svh ----
// Register offsets, field positions, reset values and timing counts
// Assumes byte-wide registers on a plain address/strobe port
`ifndef SCRB_DEFS_SVH
`define SCRB_DEFS_SVH

`define SCRB_ADDR_CONTROL_A  5'h00
`define SCRB_ADDR_STATUS     5'h01
`define SCRB_ADDR_IRQEN      5'h02
`define SCRB_ADDR_FLAGS      5'h03
`define SCRB_ADDR_TEMP       5'h04
`define SCRB_ADDR_DBG        5'h05
`define SCRB_ADDR_CLOCK_SEL  5'h07
`define SCRB_ADDR_CNT_L      5'h08
`define SCRB_ADDR_CNT_H      5'h09
`define SCRB_ADDR_TOP_L      5'h0a
`define SCRB_ADDR_TOP_H      5'h0b
`define SCRB_ADDR_CMP_L      5'h0c
`define SCRB_ADDR_CMP_H      5'h0d
`define SCRB_ADDR_TICKCTL    5'h10
`define SCRB_ADDR_TICKSTAT   5'h11
`define SCRB_ADDR_TICKIRQEN  5'h12
`define SCRB_ADDR_TICKFLAG   5'h13
`define SCRB_ADDR_TICKDBG    5'h15

`define SCRB_BIT_STBY_RUN    7
`define SCRB_DIV_HI          6
`define SCRB_DIV_LO          3
`define SCRB_BIT_EN          0
`define SCRB_BIT_CMP         1
`define SCRB_BIT_WRAP        0
`define SCRB_BIT_BUSY_CMP    3
`define SCRB_BIT_BUSY_TOP    2
`define SCRB_BIT_BUSY_CNT    1
`define SCRB_BIT_BUSY_CTL    0

`define SCRB_RESET_BYTE      8'h00
`define SCRB_RESET_TOP       16'hffff
`define SCRB_SYNC_CYCLES     2'h2

`endif

// ---- core/scrb_pkg.sv ----
// Types shared by the slow counter register bank
// Assumes the defines header is included where offsets are needed
package scrb_pkg;
    typedef enum logic [2:0] {
        SCRB_SYNC_IDLE = 3'b001,
        SCRB_SYNC_WAIT = 3'b010,
        SCRB_SYNC_DONE = 3'b100
    } scrb_sync_t;
endpackage

// ---- core/scrb_bank.sv ----
// Register bank and 16-bit slow counter with domain-sync emulation
// Assumes one 100 MHz clock; slow clock edges arrive as slow_tick enable
//
// Summary of operation
// RULE1: standby_run 0 halts counter in standby; 1 keeps it running there.
// RULE2: tick_divider field divides slow ticks by two to the field value.
// RULE3: control A writes reach counter logic two slow ticks later.
// RULE4: software waits for control_sync_busy low before writing control A.
// RULE5: counter_enable bit 0 starts or stops the counter; resets to 0.
// RULE6: compare_sync_busy high while a compare value is being transferred.
// RULE7: top_sync_busy high while a wrap top value is being transferred.
// RULE8: count_sync_busy high while a count value is being transferred.
// RULE9: control_sync_busy high while control A transfers; status resets 0.
// RULE10: compare interrupt enable gates compare match request.
// RULE11: wrap interrupt enable gates wrap event request.
// RULE12: compare_match flag sets on count equal compare, enable or not.
// RULE13: wrap_event flag sets when count wraps from top to zero.
// RULE14: writing 1 clears a flag, 0 leaves it; flags reset to 0.
// RULE15: one shared high byte buffer serves all 16-bit registers.
// RULE16: shared buffer gives atomic 16-bit access, direct access, resets 0.
// RULE17: request active while flag and enable set, until flag cleared.
// RULE18: divider runs when counter_enable or tick_enable is set, else stops.
// RULE19: clock_source_select picks slow clock: 0 32k, 1 1k, 3 external.
// RULE20: enabled counter steps on divided tick, wraps to zero after top.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "scrb_defs.svh"

module scrb_bank #(
    parameter int DIV_WIDTH = 15
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [4:0]  address,
    input  wire logic [7:0]  write_data,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    input  wire logic        slow_tick_32k,
    input  wire logic        slow_tick_1k,
    input  wire logic        slow_tick_ext,
    input  wire logic        standby_sleep,
    input  wire logic        debug_halt,
    output logic      [7:0]  read_data,
    output logic      [15:0] count_out,
    output logic             irq_request,
    output logic             wrap_pulse,
    output logic             compare_pulse
);
    logic [7:0]  control_a;
    logic [7:0]  irq_enable;
    logic [1:0]  irq_flags;
    logic [7:0]  shared_high_byte_buffer;
    logic        debug_keep_running;
    logic [1:0]  clock_source_select;
    logic [7:0]  tick_control;
    logic        tick_irq_enable;
    logic        tick_debug_control;

    // Staged values waiting for a slow tick, and their live copies
    logic [7:0]  ctl_stage;
    logic [15:0] cnt_stage;
    logic [15:0] top_stage;
    logic [15:0] cmp_stage;
    logic [7:0]  ctl_live;
    logic [15:0] count_value;
    logic [15:0] wrap_top_value;
    logic [15:0] compare_value;
    logic [DIV_WIDTH-1:0] divider;
    logic        slow_tick;
    logic        div_tick;
    logic        run_ok;
    logic        step;
    logic        hit_top;
    logic        hit_cmp;
    logic        wr_hi;

    logic        wr;
    assign wr = write_strobe;

    // Source selection of the slow timebase edge; code 2 gives no edges
    always_comb begin
        unique case (clock_source_select)
            2'h0: slow_tick = slow_tick_32k; // RULE19
            2'h1: slow_tick = slow_tick_1k; // RULE19
            2'h3: slow_tick = slow_tick_ext; // RULE19
            default: slow_tick = 1'b0;
        endcase
    end

    // Four staged register transfers, each a small sync state machine
    logic [3:0] busy;
    logic [3:0] start;
    logic [3:0] land;
    assign start[`SCRB_BIT_BUSY_CTL] = wr && address == `SCRB_ADDR_CONTROL_A;
    assign start[`SCRB_BIT_BUSY_CNT] = wr && address == `SCRB_ADDR_CNT_H;
    assign start[`SCRB_BIT_BUSY_TOP] = wr && address == `SCRB_ADDR_TOP_H;
    assign start[`SCRB_BIT_BUSY_CMP] = wr && address == `SCRB_ADDR_CMP_H;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            scrb_pkg::scrb_sync_t state;
            logic [1:0] ticks;
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    state <= scrb_pkg::SCRB_SYNC_IDLE;
                    ticks <= 2'h0;
                end else if (start[g]) begin
                    state <= scrb_pkg::SCRB_SYNC_WAIT;
                    ticks <= 2'h0;
                end else begin
                    unique case (state)
                        scrb_pkg::SCRB_SYNC_IDLE: ticks <= 2'h0;
                        scrb_pkg::SCRB_SYNC_WAIT: begin
                            if (slow_tick) begin
                                ticks <= ticks + 2'h1;
                                if (ticks + 2'h1 == `SCRB_SYNC_CYCLES) begin
                                    state <= scrb_pkg::SCRB_SYNC_DONE; // RULE3
                                end
                            end
                        end
                        scrb_pkg::SCRB_SYNC_DONE:
                            state <= scrb_pkg::SCRB_SYNC_IDLE;
                        default: state <= scrb_pkg::SCRB_SYNC_IDLE;
                    endcase
                end
            end
            assign busy[g] =
                state != scrb_pkg::SCRB_SYNC_IDLE; // RULE6 RULE7 RULE8 RULE9
            assign land[g] = state == scrb_pkg::SCRB_SYNC_DONE;
        end
    endgenerate

    // Software-side registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control_a           <= `SCRB_RESET_BYTE; // RULE5
            irq_enable          <= `SCRB_RESET_BYTE;
            debug_keep_running  <= 1'b0;
            clock_source_select <= 2'h0;
            tick_control        <= `SCRB_RESET_BYTE;
            tick_irq_enable     <= 1'b0;
            tick_debug_control  <= 1'b0;
            ctl_stage           <= `SCRB_RESET_BYTE;
        end else if (wr) begin
            unique case (address)
                `SCRB_ADDR_CONTROL_A: begin
                    control_a <= write_data & 8'hf9;
                    ctl_stage <= write_data & 8'hf9;
                end
                `SCRB_ADDR_IRQEN:    irq_enable <= write_data & 8'h03;
                `SCRB_ADDR_DBG:      debug_keep_running <= write_data[0];
                `SCRB_ADDR_CLOCK_SEL: clock_source_select <= write_data[1:0];
                `SCRB_ADDR_TICKCTL:  tick_control <= write_data & 8'h79;
                `SCRB_ADDR_TICKIRQEN: tick_irq_enable <= write_data[0];
                `SCRB_ADDR_TICKDBG:  tick_debug_control <= write_data[0];
                default: ;
            endcase
        end
    end

    // Shared high byte: low-byte read latches high half, high write pairs it
    assign wr_hi = wr && (address == `SCRB_ADDR_CNT_H ||
                   address == `SCRB_ADDR_TOP_H || address == `SCRB_ADDR_CMP_H);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shared_high_byte_buffer <= `SCRB_RESET_BYTE; // RULE16
        end else if (wr && (address == `SCRB_ADDR_TEMP ||
                     address == `SCRB_ADDR_CNT_L ||
                     address == `SCRB_ADDR_TOP_L ||
                     address == `SCRB_ADDR_CMP_L)) begin
            shared_high_byte_buffer <= write_data; // RULE15
        end else if (read_strobe) begin
            unique case (address)
                `SCRB_ADDR_CNT_L: shared_high_byte_buffer <= count_value[15:8];
                `SCRB_ADDR_TOP_L:
                    shared_high_byte_buffer <= wrap_top_value[15:8];
                `SCRB_ADDR_CMP_L:
                    shared_high_byte_buffer <= compare_value[15:8];
                default: ;
            endcase
        end
    end

    // High-byte write joins buffered low byte into one 16-bit stage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_stage <= 16'h0000;
            top_stage <= `SCRB_RESET_TOP;
            cmp_stage <= 16'h0000;
        end else if (wr_hi) begin
            unique case (address)
                `SCRB_ADDR_CNT_H:
                    cnt_stage <= {write_data, shared_high_byte_buffer}; // RULE16
                `SCRB_ADDR_TOP_H:
                    top_stage <= {write_data, shared_high_byte_buffer};
                default: cmp_stage <= {write_data, shared_high_byte_buffer};
            endcase
        end
    end

    // Live copies take staged values once transfer completes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctl_live       <= `SCRB_RESET_BYTE;
            wrap_top_value <= `SCRB_RESET_TOP;
            compare_value  <= 16'h0000;
        end else begin
            if (land[`SCRB_BIT_BUSY_CTL]) ctl_live <= ctl_stage; // RULE3
            if (land[`SCRB_BIT_BUSY_TOP]) wrap_top_value <= top_stage;
            if (land[`SCRB_BIT_BUSY_CMP]) compare_value <= cmp_stage;
        end
    end

    // Shared prescaler: free-running while either function is on
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            divider <= '0;
        end else if (!(ctl_live[`SCRB_BIT_EN] || tick_control[0])) begin
            divider <= '0; // RULE18
        end else if (slow_tick) begin
            divider <= divider + 1'b1;
        end
    end

    // Tick when all low divider bits below the selected power are ones
    always_comb begin
        logic [DIV_WIDTH-1:0] mask;
        mask = '0;
        for (int i = 0; i < DIV_WIDTH; i++) begin
            if (i < int'(ctl_live[`SCRB_DIV_HI:`SCRB_DIV_LO])) mask[i] = 1'b1;
        end
        div_tick = slow_tick && ((divider & mask) == mask); // RULE2
    end

    assign run_ok = (!standby_sleep ||
                     ctl_live[`SCRB_BIT_STBY_RUN]) && // RULE1
                    (!debug_halt || debug_keep_running);
    assign step = ctl_live[`SCRB_BIT_EN] && run_ok && div_tick; // RULE5
    assign hit_top = step && count_value == wrap_top_value;
    assign hit_cmp = step && count_value + 16'h1 == compare_value &&
                     !hit_top;

    // Counter
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_value <= 16'h0000;
        end else if (land[`SCRB_BIT_BUSY_CNT]) begin
            count_value <= cnt_stage;
        end else if (hit_top) begin
            count_value <= 16'h0000; // RULE20
        end else if (step) begin
            count_value <= count_value + 16'h1; // RULE20
        end
    end

    // Flags: hardware set wins over a write-one clear
    logic hit_cmp_any;
    assign hit_cmp_any = hit_cmp || (hit_top && compare_value == 16'h0000);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_flags <= 2'b00; // RULE14
        end else begin
            irq_flags[`SCRB_BIT_CMP] <= hit_cmp_any || // RULE12
                (irq_flags[`SCRB_BIT_CMP] &&
                 !(wr && address == `SCRB_ADDR_FLAGS &&
                   write_data[`SCRB_BIT_CMP])); // RULE14
            irq_flags[`SCRB_BIT_WRAP] <= hit_top || // RULE13
                (irq_flags[`SCRB_BIT_WRAP] &&
                 !(wr && address == `SCRB_ADDR_FLAGS &&
                   write_data[`SCRB_BIT_WRAP])); // RULE14
        end
    end

    // Outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_request   <= 1'b0;
            wrap_pulse    <= 1'b0;
            compare_pulse <= 1'b0;
            count_out     <= 16'h0000;
        end else begin
            irq_request <=
                |(irq_flags & irq_enable[1:0]); // RULE10 RULE11 RULE17
            wrap_pulse    <= hit_top;
            compare_pulse <= hit_cmp_any;
            count_out     <= count_value;
        end
    end

    // Read port, data valid the cycle after the strobe
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data <= `SCRB_RESET_BYTE;
        end else if (read_strobe) begin
            unique case (address)
                `SCRB_ADDR_CONTROL_A: read_data <= control_a;
                `SCRB_ADDR_STATUS:  read_data <= {4'h0, busy}; // RULE9
                `SCRB_ADDR_IRQEN:   read_data <= irq_enable;
                `SCRB_ADDR_FLAGS:   read_data <= {6'h00, irq_flags};
                `SCRB_ADDR_TEMP:    read_data <= shared_high_byte_buffer;
                `SCRB_ADDR_DBG:     read_data <= {7'h00, debug_keep_running};
                `SCRB_ADDR_CLOCK_SEL:
                    read_data <= {6'h00, clock_source_select};
                `SCRB_ADDR_CNT_L:   read_data <= count_value[7:0];
                `SCRB_ADDR_TOP_L:   read_data <= wrap_top_value[7:0];
                `SCRB_ADDR_CMP_L:   read_data <= compare_value[7:0];
                `SCRB_ADDR_CNT_H, `SCRB_ADDR_TOP_H, `SCRB_ADDR_CMP_H:
                    read_data <= shared_high_byte_buffer; // RULE16
                `SCRB_ADDR_TICKCTL:  read_data <= tick_control;
                `SCRB_ADDR_TICKSTAT: read_data <= 8'h00;
                `SCRB_ADDR_TICKIRQEN: read_data <= {7'h00, tick_irq_enable};
                `SCRB_ADDR_TICKFLAG: read_data <= 8'h00;
                `SCRB_ADDR_TICKDBG:  read_data <= {7'h00, tick_debug_control};
                default:            read_data <= 8'h00;
            endcase
        end else begin
            read_data <= 8'h00;
        end
    end
endmodule

// ---- verif/scrb_bank_assertions.sv ----
// Concurrent checks on the register bank ports
// Assumes slow ticks arrive at least four clocks apart
`timescale 1ns/100ps
module scrb_bank_assertions (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [4:0]  address,
    input wire logic [7:0]  write_data,
    input wire logic        write_strobe,
    input wire logic        read_strobe,
    input wire logic [7:0]  read_data,
    input wire logic [15:0] count_out,
    input wire logic        irq_request,
    input wire logic        wrap_pulse,
    input wire logic        compare_pulse
);
    logic [7:0] temp_seen;
    wire        irq_wr = write_strobe && address inside {5'h02, 5'h03};
    wire        temp_wr = write_strobe &&
                          address inside {5'h04, 5'h08, 5'h0a, 5'h0c};

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Last byte that software placed in the shared buffer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            temp_seen <= 8'h00;
        end else if (temp_wr) begin
            temp_seen <= write_data;
        end
    end

    sequence wr_to(a); write_strobe && address == a; endsequence
    sequence rd_of(a); read_strobe && address == a; endsequence
    sequence busy_probe(a); wr_to(a) ##[1:2] rd_of(5'h01); endsequence

    AST_CTL_BUSY: assert property (busy_probe(5'h00) |=> read_data[0])
        else $error("control busy low right after control write");
    AST_CNT_BUSY: assert property (busy_probe(5'h09) |=> read_data[1])
        else $error("count busy low right after count write");
    AST_TOP_BUSY: assert property (busy_probe(5'h0b) |=> read_data[2])
        else $error("top busy low right after top write");
    AST_CMP_BUSY: assert property (busy_probe(5'h0d) |=> read_data[3])
        else $error("compare busy low right after compare write");
    AST_STATUS_RO: assert property (rd_of(5'h01) |=>
        read_data[7:4] == 4'h0)
        else $error("status upper bits not zero");
    AST_TEMP_RD: assert property (wr_to(5'h04) ##[1:2] rd_of(5'h04)
        |=> read_data == temp_seen)
        else $error("shared buffer read differs from last write");
    AST_IRQ_HOLD: assert property (irq_request && !irq_wr
        && !$past(irq_wr) |=> irq_request)
        else $error("request dropped without flag or enable write");
    AST_WRAP_ZERO: assert property (wrap_pulse |->
        ##[0:1] count_out == 16'h0000)
        else $error("count not zero at wrap");
    AST_WRAP_PULSE: assert property (wrap_pulse |=> !wrap_pulse)
        else $error("wrap pulse longer than one cycle");
    AST_CMP_PULSE: assert property (compare_pulse |=> !compare_pulse)
        else $error("compare pulse longer than one cycle");
endmodule

bind scrb_bank scrb_bank_assertions u_chk (.clock, .reset, .address,
    .write_data, .write_strobe, .read_strobe, .read_data, .count_out,
    .irq_request, .wrap_pulse, .compare_pulse);

// ---- verif/slow_counter_register_bank_tb.sv ----
// Self-checking bench for the slow counter register bank
// Assumes reads answer one clock later and slow ticks are enable pulses
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module slow_counter_register_bank_tb;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  address = 5'h00;
    logic [7:0]  write_data = 8'h00;
    logic        write_strobe = 1'b0;
    logic        read_strobe = 1'b0;
    logic [2:0]  slow = 3'h0;
    logic        standby_sleep = 1'b0;
    logic        debug_halt = 1'b0;
    logic [7:0]  read_data;
    logic [15:0] count_out;
    logic        irq_request;
    logic        wrap_pulse;
    logic        compare_pulse;
    logic [7:0]  v;
    logic [15:0] c;
    int          err_total = 0;
    int          checked = 0;
    int          wraps = 0;
    int          cmps = 0;
    int          w0;
    int          m0;

    always #5 clock = ~clock;

    // Pulse counters for the event outputs
    always @(posedge clock) begin
        if (wrap_pulse) wraps++;
        if (compare_pulse) cmps++;
    end

    scrb_bank i_dut (.clock, .reset, .address, .write_data, .write_strobe,
        .read_strobe, .slow_tick_32k(slow[0]), .slow_tick_1k(slow[1]),
        .slow_tick_ext(slow[2]), .standby_sleep, .debug_halt, .read_data,
        .count_out, .irq_request, .wrap_pulse, .compare_pulse);

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 v = read_data;
    endtask

    // One slow edge per pulse, spaced so busy and count settle
    task automatic tick(input int s, input int n);
        repeat (n) begin
            @(posedge clock);
            slow[s] <= 1'b1;
            @(posedge clock);
            slow[s] <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask

    task automatic t_reset();
        wr(5'h01, 8'hff);
        wr(5'h06, 8'hff);
        for (int a = 0; a < 8; a++) begin
            rd(a[4:0]);
            `CHK(v, 8'h00)
        end
        wr(5'h04, 8'ha5);
        rd(5'h04);
        `CHK(v, 8'ha5)
        wr(5'h0c, 8'h5a);
        rd(5'h04);
        `CHK(v, 8'h5a)
    endtask

    task automatic t_ctrl();
        wr(5'h00, 8'h01);
        rd(5'h01);
        `CHK(v[0], 1'b1)
        tick(0, 1);
        rd(5'h01);
        `CHK(v[0], 1'b1)
        `CHK(count_out, 16'h0000)
        tick(0, 1);
        rd(5'h01);
        `CHK(v[0], 1'b0)
        tick(0, 3);
        `CHK(count_out, 16'h0003)
        @(posedge clock);
        standby_sleep <= 1'b1;
        tick(0, 2);
        `CHK(count_out, 16'h0003)
        rd(5'h01);
        `CHK(v[0], 1'b0)
        wr(5'h00, 8'h81);
        tick(0, 4);
        `CHK(count_out, 16'h0005)
        standby_sleep <= 1'b0;
        wr(5'h00, 8'h11);
        tick(0, 2);
        c = count_out;
        tick(0, 8);
        `CHK(count_out, c + 16'h0002)
        wr(5'h00, 8'h01);
        tick(0, 2);
    endtask

    task automatic t_irq();
        logic [4:0] ad [3] = '{5'h0a, 5'h0c, 5'h08};
        logic [7:0] vl [3] = '{8'h03, 8'h02, 8'h00};
        int         bt [3] = '{2, 3, 1};
        for (int i = 0; i < 3; i++) begin
            wr(ad[i], vl[i]);
            wr(ad[i] + 5'h01, 8'h00);
            rd(5'h01);
            `CHK(v[bt[i]], 1'b1)
            tick(0, 2);
        end
        wr(5'h03, 8'h03);
        w0 = wraps;
        m0 = cmps;
        tick(0, 6);
        `CHK(count_out, 16'h0002)
        `CHK(wraps - w0, 1)
        `CHK(cmps - m0, 2)
        rd(5'h03);
        `CHK(v, 8'h03)
        `CHK(irq_request, 1'b0)
        wr(5'h02, 8'h02);
        repeat (2) @(posedge clock);
        `CHK(irq_request, 1'b1)
        wr(5'h03, 8'h00);
        rd(5'h03);
        `CHK(v, 8'h03)
        wr(5'h03, 8'h02);
        rd(5'h03);
        `CHK(v, 8'h01)
        `CHK(irq_request, 1'b0)
        wr(5'h02, 8'h03);
        repeat (2) @(posedge clock);
        `CHK(irq_request, 1'b1)
        wr(5'h03, 8'h01);
        rd(5'h03);
        `CHK(v, 8'h00)
        `CHK(irq_request, 1'b0)
    endtask

    task automatic t_clock_source_select();
        for (int k = 0; k < 4; k++) begin
            wr(5'h07, k[7:0]);
            tick(0, 1);
            tick(1, 1);
            tick(2, 1);
            c = count_out;
            tick(0, 1);
            tick(1, 1);
            tick(2, 1);
            `CHK(count_out, (k == 2) ? c : (c + 16'h1) % 16'h4)
        end
    endtask

    // Stopped prescaler restarts from zero; tick_enable alone keeps it going
    task automatic t_prescale();
        wr(5'h07, 8'h00);
        wr(5'h00, 8'h10);
        tick(0, 4);
        wr(5'h10, 8'h01);
        tick(0, 1);
        wr(5'h00, 8'h11);
        tick(0, 2);
        c = count_out;
        tick(0, 1);
        `CHK(count_out, (c + 16'h1) % 16'h4)
    endtask

    task automatic give_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_ctrl();
        t_irq();
        t_clock_source_select();
        t_prescale();
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        give_verdict();
    end
endmodule
